// ---- dv/imac_rf_model.sv ----
`timescale 1ns/1ps
module imac_rf_model
    import imac_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // write-back and status updates from the unit
    input wire logic wr_lo_en_r,
    input wire logic wr_hi_en_r,
    input wire logic nz_wr_r,
    input wire logic flag_n_r,
    input wire logic flag_z_r,
    input wire logic q_set_r,
    // state seen by the core
    output logic [31:0] wr_count,
    output logic [2:0] nzq_flags
);
    // counts register writes and keeps N, Z and the sticky Q bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_count <= IMAC_WORD_ZERO;
            nzq_flags <= 3'h0;
        end else begin
            wr_count <= wr_count + 32'(wr_lo_en_r) + 32'(wr_hi_en_r);
            if (nz_wr_r) begin
                nzq_flags[2:1] <= {flag_n_r, flag_z_r};
            end
            if (q_set_r) begin
                nzq_flags[0] <= 1'b1;
            end
        end
    end
endmodule : imac_rf_model

// ---- dv/imac_unit_tb.sv ----
`timescale 1ns/1ps
module imac_unit_tb import imac_pkg::*;;
    typedef struct {
        imac_op_e op;
        logic [2:0] s;
        logic [31:0] a, b, c, lo, hi;
        logic [64:0] exp;
    } imac_row_s;
    logic ref_clk, rst, issue_valid, cond_pass, set_flags, x_top, y_top;
    logic crossed, dest_given, sw_wr, sw_rd, wr_lo_en_r, wr_hi_en_r;
    logic nz_wr_r, flag_n_r, flag_z_r, q_set_r, en_on, h;
    imac_op_e issue_op;
    logic [3:0] first_operand_idx, second_operand_idx, dest_idx, sw_addr;
    logic [3:0] dest_low_word_idx, dest_high_word_idx, wr_lo_idx_r;
    logic [3:0] wr_hi_idx_r;
    logic [31:0] first_operand_reg, second_operand_reg, accumulate_reg;
    logic [31:0] dest_low_word_reg, dest_high_word_reg, sw_wdata;
    logic [31:0] sw_rdata_r, wr_lo_data_r, wr_hi_data_r, wr_count, c0;
    logic [2:0] nzq_flags;
    logic [64:0] e;
    imac_row_s rows[$];
    int err_total, total_checks, cyc, n_exec;

    imac_unit dut_u (.ref_clk, .rst, .issue_valid, .issue_op, .cond_pass,
        .set_flags, .x_top, .y_top, .crossed, .dest_given,
        .first_operand_idx, .second_operand_idx, .dest_idx,
        .dest_low_word_idx, .dest_high_word_idx, .first_operand_reg,
        .second_operand_reg, .accumulate_reg, .dest_low_word_reg,
        .dest_high_word_reg, .wr_lo_en_r, .wr_lo_idx_r, .wr_lo_data_r,
        .wr_hi_en_r, .wr_hi_idx_r, .wr_hi_data_r, .nz_wr_r, .flag_n_r,
        .flag_z_r, .q_set_r, .sw_addr, .sw_wdata, .sw_wr, .sw_rd,
        .sw_rdata_r);
    imac_rf_model model_u (.ref_clk, .rst, .wr_lo_en_r, .wr_hi_en_r,
        .nz_wr_r, .flag_n_r, .flag_z_r, .q_set_r, .wr_count, .nzq_flags);

    // independent arithmetic reference: {saturation, 64-bit result}
    function automatic logic [64:0] ref_calc(logic [3:0] op, logic [2:0] s,
            logic [31:0] a, b, c, lo, hi);
        logic [63:0] dl, r;
        logic signed [63:0] ha, hb, ta, tb, ba, bb;
        dl = {hi, lo};
        ha = $signed(s[2] ? a[31:16] : a[15:0]);
        hb = $signed(s[1] ? b[31:16] : b[15:0]);
        ta = $signed(a[31:16]);
        ba = $signed(a[15:0]);
        tb = $signed(s[0] ? b[15:0] : b[31:16]);
        bb = $signed(s[0] ? b[31:16] : b[15:0]);
        case (op)
            4'h0, 4'h3: r = a * b;
            4'h1: r = a * b + c;
            4'h2: r = c - a * b;
            4'h4: r = a * b + hi + lo;
            4'h5: r = a * b + dl;
            4'h6: r = ha * hb + $signed(c);
            4'h7: r = (($signed(a) * hb) >>> 16) + $signed(c);
            4'h8: r = ta * tb + ba * bb + $signed(c);
            4'h9: r = $signed(a) * $signed(b) + $signed(dl);
            4'hA: r = ha * hb + $signed(dl);
            default: r = ta * tb + ba * bb + $signed(dl);
        endcase
        return {(op == 4'h6 || op == 4'h7) && (r[32] != r[31]), r};
    endfunction : ref_calc

    task automatic add(logic [3:0] op, logic [2:0] s, logic [31:0] a, b,
            c, lo, hi);
        rows.push_back('{imac_op_e'(op), s, a, b, c, lo, hi,
            ref_calc(op, s, a, b, c, lo, hi)});
    endtask : add

    task automatic chk_w(logic [31:0] g, logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            err_total++;
            $display("wrong value t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk_w

    task automatic chk_b(logic g, logic x);
        chk_w({31'h0, g}, {31'h0, x});
    endtask : chk_b

    // m = {cond_pass, set_flags, dest_given, x_top, y_top, crossed}
    task automatic issue(logic [3:0] op, logic [5:0] m, logic [31:0] a, b,
            c, lo, hi);
        @(posedge ref_clk);
        issue_valid <= 1'b1;
        issue_op <= imac_op_e'(op);
        {cond_pass, set_flags, dest_given, x_top, y_top, crossed} <= m;
        {first_operand_reg, second_operand_reg, accumulate_reg,
            dest_low_word_reg, dest_high_word_reg} <= {a, b, c, lo, hi};
        @(posedge ref_clk);
        issue_valid <= 1'b0;
        if (m[5] && en_on) begin
            n_exec++;
        end
        #1;
    endtask : issue

    task automatic sw_acc(logic w, logic [3:0] ad, logic [31:0] d);
        @(posedge ref_clk);
        sw_wr <= w;
        sw_rd <= !w;
        sw_addr <= ad;
        sw_wdata <= d;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
        sw_rd <= 1'b0;
        #1;
    endtask : sw_acc

    task automatic final_report;
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            final_report;
        end
    end

    initial begin
        rst = 1'b1;
        {issue_valid, cond_pass, set_flags, x_top, y_top} = 5'h0;
        {crossed, dest_given, sw_wr, sw_rd, en_on} = 5'h1;
        issue_op = product_low_word_op;
        // low registers, no stack pointer or program counter
        first_operand_idx = 4'h1;
        {second_operand_idx, dest_idx} = 8'h33;
        {dest_low_word_idx, dest_high_word_idx} = 8'h45;
        {first_operand_reg, second_operand_reg, accumulate_reg} = 96'h0;
        {dest_low_word_reg, dest_high_word_reg, sw_wdata} = 96'h0;
        sw_addr = 4'h0;
        add(4'h0, 3'h0, 32'hFFFFFFFF, 32'hFFFFFFFE, 32'h0, 32'h0, 32'h0);
        add(4'h1, 3'h0, 32'h12345678, 32'h9ABCDEF0, 32'h11111111, 32'h0,
            32'h0);
        add(4'h2, 3'h0, 32'h7, 32'hFFFFFFFD, 32'h5, 32'h0, 32'h0);
        add(4'h3, 3'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0);
        add(4'h4, 3'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF,
            32'hFFFFFFFF);
        add(4'h5, 3'h0, 32'hFFFFFFFF, 32'h2, 32'h0, 32'hFFFFFFFF, 32'h1);
        add(4'h6, 3'h0, 32'hAAAA7FFF, 32'h55557FFF, 32'h7FFF0000, 0, 0);
        add(4'h6, 3'h6, 32'h80001234, 32'h7FFF9999, 32'h7FFFFFFF, 0, 0);
        add(4'h7, 3'h2, 32'h80000000, 32'h80000001, 32'h40000000, 0, 0);
        add(4'h7, 3'h0, 32'h12345678, 32'hABCD8001, 32'h1, 32'h0, 32'h0);
        add(4'h8, 3'h0, 32'h80007FFF, 32'h80007FFF, 32'h0, 32'h0, 32'h0);
        add(4'h8, 3'h1, 32'h20003, 32'h50007, 32'h10, 32'h0, 32'h0);
        add(4'h9, 3'h0, 32'hFFFFFFFF, 32'h2, 32'h0, 32'h1, 32'h0);
        add(4'hA, 3'h2, 32'h8000, 32'h7FFF1234, 32'h0, 32'h5, 32'h0);
        add(4'hB, 3'h1, 32'h80000001, 32'h80007FFF, 0, 32'hFFFFFFFF, 0);
        repeat (20) @(posedge ref_clk);
        chk_b(wr_lo_en_r | wr_hi_en_r | q_set_r | nz_wr_r, 1'b0);
        rst <= 1'b0;
        sw_acc(1'b0, IMAC_CTRL_OFS, 32'h0);
        chk_w(sw_rdata_r, 32'h1);
        sw_acc(1'b0, IMAC_COUNT_OFS, 32'h0);
        chk_w(sw_rdata_r, IMAC_COUNT_RST);
        sw_acc(1'b0, 4'hC, 32'h0);
        chk_w(sw_rdata_r, 32'h0);
        foreach (rows[i]) begin
            e = rows[i].exp;
            h = rows[i].op inside {4'h3, 4'h4, 4'h5, 4'h9, 4'hA, 4'hB};
            issue(rows[i].op, {3'h5, rows[i].s}, rows[i].a, rows[i].b,
                rows[i].c, rows[i].lo, rows[i].hi);
            chk_w(wr_lo_data_r, e[31:0]);
            chk_b(wr_lo_en_r, 1'b1);
            chk_w(wr_lo_idx_r, h ? 4'h4 : 4'h3);
            chk_b(wr_hi_en_r, h);
            if (h) begin
                chk_w(wr_hi_data_r, e[63:32]);
                chk_w(wr_hi_idx_r, 4'h5);
            end
            chk_b(q_set_r, e[64]);
            chk_b(nz_wr_r, 1'b0);
        end
        sw_acc(1'b0, IMAC_STATUS_OFS, 32'h0);
        chk_w(sw_rdata_r, 32'h1);
        chk_b(nzq_flags[0], 1'b1);
        sw_acc(1'b1, IMAC_STATUS_OFS, 32'h1);
        sw_acc(1'b0, IMAC_STATUS_OFS, 32'h0);
        chk_w(sw_rdata_r, 32'h0);
        // overflow and clear in one cycle: the set wins
        fork
            issue(4'h6, 6'h28, 32'h7FFF, 32'h7FFF, 32'h7FFF0000, 0, 0);
            sw_acc(1'b1, IMAC_STATUS_OFS, 32'h1);
        join
        sw_acc(1'b0, IMAC_STATUS_OFS, 32'h0);
        chk_w(sw_rdata_r, 32'h1);
        issue(4'h0, 6'h38, 32'h10000, 32'h10000, 0, 0, 0);
        chk_b(nz_wr_r, 1'b1);
        chk_w({flag_n_r, flag_z_r}, 2'h1);
        issue(4'h0, 6'h38, 32'hFFFFFFFF, 32'h3, 0, 0, 0);
        chk_w({nz_wr_r, flag_n_r, flag_z_r}, 3'h6);
        issue(4'h3, 6'h38, 32'h0, 32'h0, 0, 0, 0);
        chk_b(nz_wr_r, 1'b0);
        @(posedge ref_clk);
        #1;
        c0 = wr_count;
        chk_w(nzq_flags[2:1], 2'h2);
        issue(4'h6, 6'h18, 32'h7FFF, 32'h7FFF, 32'h7FFF0000, 0, 0);
        chk_w({wr_lo_en_r, wr_hi_en_r, q_set_r, nz_wr_r}, 4'h0);
        issue(4'h9, 6'h10, 32'h1, 32'h1, 0, 0, 0);
        chk_w({wr_lo_en_r, wr_hi_en_r, nz_wr_r}, 3'h0);
        @(posedge ref_clk);
        #1;
        chk_w(wr_count, c0);
        issue(4'h1, 6'h20, 32'h3, 32'h4, 32'h5, 0, 0);
        chk_w(wr_lo_idx_r, first_operand_idx);
        chk_w(wr_lo_data_r, 32'h11);
        sw_acc(1'b1, IMAC_CTRL_OFS, 32'h0);
        en_on = 1'b0;
        issue(4'h0, 6'h28, 32'h3, 32'h4, 0, 0, 0);
        chk_b(wr_lo_en_r, 1'b0);
        sw_acc(1'b1, IMAC_CTRL_OFS, 32'h1);
        sw_acc(1'b0, IMAC_COUNT_OFS, 32'h0);
        chk_w(sw_rdata_r, 32'(n_exec));
        final_report;
    end
endmodule : imac_unit_tb

// ---- verilog/imac_pkg.sv ----
package imac_pkg;

    // operation codes presented by the instruction decoder
    typedef enum logic [3:0] {
        product_low_word_op           = 4'h0,
        product_plus_addend_op        = 4'h1,
        addend_minus_product_op       = 4'h2,
        unsigned_wide_product_op      = 4'h3,
        unsigned_wide_double_accum_op = 4'h4,
        unsigned_wide_accum_op        = 4'h5,
        signed_half_accum_op          = 4'h6,
        signed_word_by_half_accum_op  = 4'h7,
        signed_dual_half_accum_op     = 4'h8,
        signed_wide_accum_op          = 4'h9,
        signed_wide_half_accum_op     = 4'hA,
        signed_wide_dual_accum_op     = 4'hB
    } imac_op_e;

    // register index width and reserved core registers
    localparam int IMAC_IDX_W = 4;
    localparam logic [3:0] IMAC_STACK_POINTER_IDX = 4'hD;
    localparam logic [3:0] IMAC_PROGRAM_COUNTER_IDX = 4'hF;
    localparam logic [3:0] IMAC_LOW_REG_LIMIT = 4'h7;

    // software register map
    localparam int IMAC_ADDR_W = 4;
    localparam logic [3:0] IMAC_CTRL_OFS = 4'h0;
    localparam logic [3:0] IMAC_STATUS_OFS = 4'h4;
    localparam logic [3:0] IMAC_COUNT_OFS = 4'h8;

    // field positions and reset values
    localparam int IMAC_CTRL_EN_BIT = 0;
    localparam int IMAC_STATUS_Q_BIT = 0;
    localparam logic IMAC_CTRL_EN_RST = 1'b1;
    localparam logic [31:0] IMAC_COUNT_RST = 32'h0000_0000;
    localparam logic [31:0] IMAC_WORD_ZERO = 32'h0000_0000;

    // result latency in clock cycles
    localparam int IMAC_LATENCY = 1;

endpackage : imac_pkg

// ---- verilog/imac_unit.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: plain product writes only the low 32 product bits to destination.
// RQ2: product plus accumulate value, low 32 bits to destination.
// RQ3: accumulate value minus product, low 32 bits to destination.
// RQ4: truncated 32-bit results ignore operand signedness; no signedness input.
// RQ5: flag-setting plain product updates N and Z only, not C or V.
// RQ6: flag-setting plain product uses R0-R7, dest equals second, no condition.
// RQ7: unsigned wide product splits 64-bit product into low and high words.
// RQ8: double accumulate adds both old destination words to the product.
// RQ9: unsigned wide accumulate adds product to the 64-bit destination pair.
// RQ10: high and low destinations of 64-bit results are distinct registers.
// RQ11: unsigned wide operations never touch any condition flag.
// RQ12: select bottom takes bits 15:0, top takes 31:16, per operand.
// RQ13: signed halfword product plus accumulate value goes to destination.
// RQ14: word by halfword: drop low 16 of 48-bit product, add accumulate.
// RQ15: overflow of halfword accumulate additions sets sticky saturation flag.
// RQ16: unselected halfwords never influence halfword accumulate results.
// RQ17: dual form adds two signed halfword products to accumulate value.
// RQ18: plain pairing top-top, bottom-bottom; crossed pairs opposite halves.
// RQ19: dual halfword accumulate leaves all status flags unchanged.
// RQ20: signed long forms: low word bits 31:0, high word bits 63:32.
// RQ21: stack pointer and program counter are never operands or destinations.
// RQ22: with no destination field the result goes to the first operand.
// RQ23: signed word long accumulate adds signed 64-bit product to the pair.
// RQ24: halfword long forms sign-extend the 32-bit product before adding.
// RQ25: failed condition writes no register and updates no flag.
module imac_unit
    import imac_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // issue from the instruction decoder
    input wire logic issue_valid,
    input wire imac_op_e issue_op,
    input wire logic cond_pass,
    input wire logic set_flags,
    input wire logic x_top,
    input wire logic y_top,
    input wire logic crossed,
    input wire logic dest_given,
    // register indices
    input wire logic [IMAC_IDX_W-1:0] first_operand_idx,
    input wire logic [IMAC_IDX_W-1:0] second_operand_idx,
    input wire logic [IMAC_IDX_W-1:0] dest_idx,
    input wire logic [IMAC_IDX_W-1:0] dest_low_word_idx,
    input wire logic [IMAC_IDX_W-1:0] dest_high_word_idx,
    // register values
    input wire logic [31:0] first_operand_reg,
    input wire logic [31:0] second_operand_reg,
    input wire logic [31:0] accumulate_reg,
    input wire logic [31:0] dest_low_word_reg,
    input wire logic [31:0] dest_high_word_reg,
    // register file write ports
    output logic wr_lo_en_r,
    output logic [IMAC_IDX_W-1:0] wr_lo_idx_r,
    output logic [31:0] wr_lo_data_r,
    output logic wr_hi_en_r,
    output logic [IMAC_IDX_W-1:0] wr_hi_idx_r,
    output logic [31:0] wr_hi_data_r,
    // program status word updates
    output logic nz_wr_r,
    output logic flag_n_r,
    output logic flag_z_r,
    output logic q_set_r,
    // software register port
    input wire logic [IMAC_ADDR_W-1:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata_r
);

    logic ctrl_en_r;
    logic status_q_r;
    logic [31:0] count_r;
    logic [31:0] count_nxt;

    wire exec = issue_valid && cond_pass && ctrl_en_r; // RQ25
    wire [31:0] a = first_operand_reg;
    wire [31:0] b = second_operand_reg;
    wire [31:0] acc = accumulate_reg;
    wire [63:0] wide_in = {dest_high_word_reg, dest_low_word_reg}; // RQ20

    // unsigned full product; its low word serves both signednesses
    wire [63:0] prod_u = {32'h0000_0000, a} * {32'h0000_0000, b}; // RQ4
    wire [31:0] prod_lo = prod_u[31:0]; // RQ1
    wire [31:0] mla_res = prod_lo + acc; // RQ2
    wire [31:0] mls_res = acc - prod_lo; // RQ3
    wire [63:0] unsigned_wide_double_accum_op_res = prod_u + {32'h0000_0000, dest_high_word_reg}
        + {32'h0000_0000, dest_low_word_reg}; // RQ8
    wire [63:0] unsigned_wide_accum_op_res = prod_u + wide_in; // RQ9

    // halfword selection; the other halves are never looked at
    wire signed [15:0] half_a = x_top ? a[31:16] : a[15:0]; // RQ12 RQ16
    wire signed [15:0] half_b = y_top ? b[31:16] : b[15:0]; // RQ12 RQ16
    wire signed [31:0] prod_hh = half_a * half_b;
    wire [32:0] half_sum = {prod_hh[31], prod_hh} + {acc[31], acc}; // RQ13
    wire half_ovf = half_sum[32] ^ half_sum[31]; // RQ15

    // word by halfword, top 32 of the 48-bit product
    wire signed [47:0] prod_wh = $signed(a) * half_b; // RQ14
    wire [31:0] prod_wh_hi = prod_wh[47:16]; // RQ14
    wire [32:0] wh_sum = {prod_wh_hi[31], prod_wh_hi} + {acc[31], acc};
    wire wh_ovf = wh_sum[32] ^ wh_sum[31]; // RQ15

    // dual halfword products with optional swap of the second operand
    wire [31:0] b_pair = crossed ? {b[15:0], b[31:16]} : b; // RQ18
    wire signed [31:0] prod_top = $signed(a[31:16]) * $signed(b_pair[31:16]);
    wire signed [31:0] prod_bot = $signed(a[15:0]) * $signed(b_pair[15:0]);
    wire [31:0] dual_res = prod_top + prod_bot + acc; // RQ17
    wire [63:0] dual_wide = {{32{prod_top[31]}}, prod_top}
        + {{32{prod_bot[31]}}, prod_bot} + wide_in;

    // signed long forms
    wire signed [63:0] prod_s = $signed(a) * $signed(b);
    wire [63:0] signed_wide_accum_op_res = prod_s + wide_in; // RQ23
    wire [63:0] half_wide = {{32{prod_hh[31]}}, prod_hh} + wide_in; // RQ24

    // destination of 32-bit results
    wire [IMAC_IDX_W-1:0] dest32_idx = dest_given ? dest_idx
        : first_operand_idx; // RQ22

    logic is_wide;
    logic [63:0] res;
    logic q_hit;

    always_comb begin
        is_wide = 1'b0;
        q_hit = 1'b0;
        res = 64'h0000_0000_0000_0000;
        case (issue_op)
            product_low_word_op: begin
                res = {32'h0000_0000, prod_lo}; // RQ1
            end
            product_plus_addend_op: begin
                res = {32'h0000_0000, mla_res}; // RQ2
            end
            addend_minus_product_op: begin
                res = {32'h0000_0000, mls_res}; // RQ3
            end
            unsigned_wide_product_op: begin
                is_wide = 1'b1;
                res = prod_u; // RQ7
            end
            unsigned_wide_double_accum_op: begin
                is_wide = 1'b1;
                res = unsigned_wide_double_accum_op_res; // RQ8
            end
            unsigned_wide_accum_op: begin
                is_wide = 1'b1;
                res = unsigned_wide_accum_op_res; // RQ9
            end
            signed_half_accum_op: begin
                res = {32'h0000_0000, half_sum[31:0]}; // RQ13
                q_hit = half_ovf; // RQ15
            end
            signed_word_by_half_accum_op: begin
                res = {32'h0000_0000, wh_sum[31:0]}; // RQ14
                q_hit = wh_ovf; // RQ15
            end
            signed_dual_half_accum_op: begin
                res = {32'h0000_0000, dual_res}; // RQ17 RQ19
            end
            signed_wide_accum_op: begin
                is_wide = 1'b1;
                res = signed_wide_accum_op_res; // RQ23
            end
            signed_wide_half_accum_op: begin
                is_wide = 1'b1;
                res = half_wide; // RQ24
            end
            signed_wide_dual_accum_op: begin
                is_wide = 1'b1;
                res = dual_wide; // RQ18 RQ20
            end
            default: begin
                res = 64'h0000_0000_0000_0000;
            end
        endcase
    end

    // only the flag-setting plain product touches N and Z
    wire nz_upd = exec && set_flags
        && (issue_op == product_low_word_op); // RQ5 RQ11 RQ19
    wire [IMAC_IDX_W-1:0] lo_idx = is_wide ? dest_low_word_idx : dest32_idx;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_lo_en_r <= 1'b0;
            wr_lo_idx_r <= '0;
            wr_lo_data_r <= IMAC_WORD_ZERO;
            wr_hi_en_r <= 1'b0;
            wr_hi_idx_r <= '0;
            wr_hi_data_r <= IMAC_WORD_ZERO;
        end else begin
            wr_lo_en_r <= exec; // RQ25
            wr_lo_idx_r <= lo_idx;
            wr_lo_data_r <= res[31:0];
            wr_hi_en_r <= exec && is_wide; // RQ7 RQ25
            wr_hi_idx_r <= dest_high_word_idx;
            wr_hi_data_r <= res[63:32];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            nz_wr_r <= 1'b0;
            flag_n_r <= 1'b0;
            flag_z_r <= 1'b0;
            q_set_r <= 1'b0;
        end else begin
            nz_wr_r <= nz_upd; // RQ5
            flag_n_r <= prod_lo[31]; // RQ5
            flag_z_r <= (prod_lo == IMAC_WORD_ZERO); // RQ5
            q_set_r <= exec && q_hit; // RQ15
        end
    end

    // software registers: enable, sticky saturation copy, op counter
    wire wr_ctrl = sw_wr && (sw_addr == IMAC_CTRL_OFS);
    wire wr_status = sw_wr && (sw_addr == IMAC_STATUS_OFS);
    wire wr_count = sw_wr && (sw_addr == IMAC_COUNT_OFS);
    wire q_clr = wr_status && sw_wdata[IMAC_STATUS_Q_BIT];
    wire q_event = exec && q_hit;
    assign count_nxt = wr_count ? sw_wdata
        : (exec ? count_r + 32'h0000_0001 : count_r);

    logic [31:0] rd_mux;
    assign rd_mux = !sw_rd ? IMAC_WORD_ZERO
        : (sw_addr == IMAC_CTRL_OFS) ? {31'h0000_0000, ctrl_en_r}
        : (sw_addr == IMAC_STATUS_OFS) ? {31'h0000_0000, status_q_r}
        : (sw_addr == IMAC_COUNT_OFS) ? count_r
        : IMAC_WORD_ZERO;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_en_r <= IMAC_CTRL_EN_RST;
            status_q_r <= 1'b0;
            count_r <= IMAC_COUNT_RST;
            sw_rdata_r <= IMAC_WORD_ZERO;
        end else begin
            if (wr_ctrl) begin
                ctrl_en_r <= sw_wdata[IMAC_CTRL_EN_BIT];
            end
            // a new overflow in the clearing cycle keeps the bit set
            status_q_r <= q_event || (status_q_r && !q_clr); // RQ15
            count_r <= count_nxt;
            sw_rdata_r <= rd_mux;
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // sign-extends a halfword to a word for the reference products
    function automatic logic [31:0] sx16(logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction : sx16

    sequence exec_op_s(imac_op_e o);
        exec && (issue_op == o);
    endsequence

    sequence long_accum_s;
        exec && ((issue_op == signed_wide_accum_op)
            || (issue_op == unsigned_wide_accum_op));
    endsequence

    mul_low_word_a: assert property ( // RQ1
        exec_op_s(product_low_word_op) |=> wr_lo_en_r
        && wr_lo_data_r == 32'($past(first_operand_reg)
        * $past(second_operand_reg)))
        else $error("plain product low word wrong");

    mla_sum_a: assert property ( // RQ2
        exec_op_s(product_plus_addend_op) |=> wr_lo_data_r
        == 32'($past(first_operand_reg) * $past(second_operand_reg)
        + $past(accumulate_reg)))
        else $error("product plus addend wrong");

    mls_diff_a: assert property ( // RQ3
        exec_op_s(addend_minus_product_op) |=> wr_lo_data_r
        == 32'($past(accumulate_reg) - $past(first_operand_reg)
        * $past(second_operand_reg)))
        else $error("addend minus product wrong");

    mul_nz_flags_a: assert property ( // RQ5
        exec_op_s(product_low_word_op) ##0 set_flags |=> nz_wr_r
        && flag_z_r == (wr_lo_data_r == IMAC_WORD_ZERO)
        && flag_n_r == wr_lo_data_r[31])
        else $error("N or Z flag wrong after flag-setting product");

    other_no_flags_a: assert property ( // RQ11
        exec && issue_op != product_low_word_op |=> !nz_wr_r)
        else $error("flags touched by non flag-setting operation");

    unsigned_wide_product_op_split_a: assert property ( // RQ7
        exec_op_s(unsigned_wide_product_op) |=> wr_lo_en_r && wr_hi_en_r
        && {wr_hi_data_r, wr_lo_data_r}
        == {32'h0000_0000, $past(first_operand_reg)}
        * {32'h0000_0000, $past(second_operand_reg)})
        else $error("unsigned wide product split wrong");

    unsigned_wide_double_accum_op_sum_a: assert property ( // RQ8
        exec_op_s(unsigned_wide_double_accum_op) |=>
        {wr_hi_data_r, wr_lo_data_r}
        == {32'h0000_0000, $past(first_operand_reg)}
        * {32'h0000_0000, $past(second_operand_reg)}
        + {32'h0000_0000, $past(dest_high_word_reg)}
        + {32'h0000_0000, $past(dest_low_word_reg)})
        else $error("double accumulate sum wrong");

    long_pair_a: assert property ( // RQ9
        long_accum_s |=> wr_hi_idx_r == $past(dest_high_word_idx)
        && wr_lo_idx_r == $past(dest_low_word_idx) && !q_set_r)
        else $error("long accumulate destinations wrong");

    dual_quiet_a: assert property ( // RQ19
        exec_op_s(signed_dual_half_accum_op) |=> !q_set_r && !nz_wr_r)
        else $error("dual accumulate touched a flag");

    cond_fail_a: assert property ( // RQ25
        issue_valid && !cond_pass |=> !wr_lo_en_r && !wr_hi_en_r
        && !nz_wr_r && !q_set_r)
        else $error("failed condition still had effect");

    dest_default_a: assert property ( // RQ22
        exec && !dest_given && !is_wide
        |=> wr_lo_idx_r == $past(first_operand_idx))
        else $error("omitted destination not first operand");

    // a clear written in the cycle after the event may drop the bit one cycle later
    q_sticky_a: assert property ( // RQ15
        q_set_r |-> status_q_r ##1 (status_q_r || $past(q_clr)))
        else $error("saturation event lost from status");

    narrow_write_a: assert property ( // RQ1
        exec && (issue_op inside {product_low_word_op,
        product_plus_addend_op, addend_minus_product_op,
        signed_half_accum_op, signed_word_by_half_accum_op,
        signed_dual_half_accum_op}) |=> wr_lo_en_r && !wr_hi_en_r)
        else $error("32-bit operation wrote a high word");

    unsigned_wide_accum_op_sum_a: assert property ( // RQ9
        exec_op_s(unsigned_wide_accum_op) |=> wr_hi_en_r
        && {wr_hi_data_r, wr_lo_data_r}
        == {32'h0000_0000, $past(first_operand_reg)}
        * {32'h0000_0000, $past(second_operand_reg)}
        + {$past(dest_high_word_reg), $past(dest_low_word_reg)})
        else $error("unsigned wide accumulate wrong");

    signed_wide_accum_op_sum_a: assert property ( // RQ23
        exec_op_s(signed_wide_accum_op) |=> {wr_hi_data_r, wr_lo_data_r}
        == {{32{$past(first_operand_reg[31])}}, $past(first_operand_reg)}
        * {{32{$past(second_operand_reg[31])}},
        $past(second_operand_reg)}
        + {$past(dest_high_word_reg), $past(dest_low_word_reg)})
        else $error("signed wide accumulate wrong");

    dual_cross_a: assert property ( // RQ18
        exec_op_s(signed_dual_half_accum_op) ##0 crossed |=> wr_lo_data_r
        == sx16($past(first_operand_reg[31:16]))
        * sx16($past(second_operand_reg[15:0]))
        + sx16($past(first_operand_reg[15:0]))
        * sx16($past(second_operand_reg[31:16])) + $past(accumulate_reg))
        else $error("crossed dual accumulate wrong");

    half_top_a: assert property ( // RQ12
        exec_op_s(signed_half_accum_op) ##0 x_top && y_top |=> wr_lo_data_r
        == sx16($past(first_operand_reg[31:16]))
        * sx16($past(second_operand_reg[31:16])) + $past(accumulate_reg))
        else $error("top halfword accumulate wrong");

endmodule : imac_unit
